// file: dac_link_pkg.sv
// Shared constants for the two-wire converter code port and its master
package dac_link_pkg;
    // Slave address: upper five bits compared, two low bits ignored
    localparam logic [4:0] ADDR_MATCH_TOP = 5'h03;
    localparam logic [7:0] ADDR_BYTE_WRITE = 8'h18;
    localparam logic [7:0] ADDR_BYTE_READ = 8'h19;
    // Input word field positions
    localparam int PD_BIT = 15;
    localparam int CODE_MSB = 13;
    localparam int CODE_LSB = 4;
    localparam int CODE_W = 10;
    // Reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] DAC_RESET = 16'h0000;
    // Serial clock timing of the master: quarter of a 400 kHz period
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCL_QUARTER_NS = 625;
    localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS * SYS_CLK_MHZ + 999) / 1000;
    // Master register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    // Master control and status bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;
endpackage

// file: dac_link_if.sv
// Two-wire link between the master and the converter code port
`timescale 1ns/1ns
interface dac_link_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl_line;
    logic sda_line;

    // Open-drain wires with pull-ups: any enabled low driver wins
    assign scl_line = ~(m_scl_oe & ~m_scl_o);
    assign sda_line = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

    modport device (
        input scl_line,
        input sda_line,
        output d_sda_o,
        output d_sda_oe
    );
    modport master (
        input scl_line,
        input sda_line,
        output m_scl_o,
        output m_scl_oe,
        output m_sda_o,
        output m_sda_oe
    );
endinterface // dac_link_if

// file: dac_code_master.sv
// Bus master end: Wishbone-controlled two-byte writer and reader
`timescale 1ns/1ns
module dac_code_master #(
    parameter int QTR_CYC = dac_link_pkg::SCL_QUARTER_CYC
) (
    // System
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Link
    dac_link_if.master LINK
);
    import dac_link_pkg::*;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_BIT = 2'b10,
        M_STOP = 2'b11
    } m_state_t;

    m_state_t st_reg, st_next;
    logic [15:0] qc_reg, qc_next;
    logic [1:0] q_reg, q_next;
    logic [3:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic [7:0] tx_reg, tx_next;
    logic [15:0] rx_reg, rx_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rd_reg, rd_next;
    logic nack_reg, nack_next;
    logic scl_low_reg, scl_low_next;
    logic sda_low_reg, sda_low_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic sda_m1_reg, sda_s_reg;
    logic tick, req, wr_go;

    ////////////////////////////////////////////////////////////////////////
    // Data line synchroniser
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sda_m1_reg <= 1'b1;
            sda_s_reg <= 1'b1;
        end else begin
            sda_m1_reg <= LINK.sda_line;
            sda_s_reg <= sda_m1_reg;
        end
    end

    assign tick = (qc_reg == 16'(QTR_CYC - 1));
    assign req = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wr_go = req & WB_WE_I & (WB_ADR_I == REG_CTRL) & WB_SEL_I[0]
        & WB_DAT_I[CTRL_GO] & (st_reg == M_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Register access and serial sequencer next state
    always_comb begin
        st_next = st_reg;
        qc_next = (st_reg == M_IDLE || tick) ? 16'h0000 : qc_reg + 16'h0001;
        q_next = q_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rd_next = rd_reg;
        nack_next = nack_reg;
        scl_low_next = scl_low_reg;
        sda_low_next = sda_low_reg;
        ack_next = req;
        dat_next = 32'h00000000;
        // Bus reads; unmapped offsets answer zero
        if (req && !WB_WE_I) begin
            case (WB_ADR_I)
                REG_DATA: dat_next = {16'h0000, rdata_reg};
                REG_STAT: dat_next = {30'h0, nack_reg, st_reg != M_IDLE};
                default: dat_next = 32'h00000000;
            endcase
        end
        // Word to send, high byte on lane 1
        if (req && WB_WE_I && WB_ADR_I == REG_DATA) begin
            if (WB_SEL_I[0])
                wdata_next[7:0] = WB_DAT_I[7:0];
            if (WB_SEL_I[1])
                wdata_next[15:8] = WB_DAT_I[15:8];
        end
        if (wr_go) begin
            st_next = M_START;
            rd_next = WB_DAT_I[CTRL_READ];
            tx_next = WB_DAT_I[CTRL_READ] ? ADDR_BYTE_READ
                : ADDR_BYTE_WRITE;
            nack_next = 1'b0;
            q_next = 2'b00;
            bit_next = 4'h0;
            byte_next = 2'b00;
        end
        if (tick) begin
            q_next = q_reg + 2'b01;
            case (st_reg)
                M_START: begin
                    // Data falls with clock high, then clock falls
                    if (q_reg == 2'b00)
                        sda_low_next = 1'b1;
                    else if (q_reg == 2'b01) begin
                        scl_low_next = 1'b1;
                        st_next = M_BIT;
                        q_next = 2'b00;
                    end
                end
                M_BIT: begin
                    case (q_reg)
                        2'b00: begin
                            // Data changes only with clock low
                            if (bit_reg != 4'h8)
                                sda_low_next = (byte_reg == 2'b00 || !rd_reg)
                                    ? ~tx_reg[7] : 1'b0;
                            else
                                sda_low_next = rd_reg && byte_reg == 2'b01;
                        end
                        2'b01: scl_low_next = 1'b0;
                        2'b10: begin
                            if (bit_reg != 4'h8 && rd_reg && byte_reg != 2'b00)
                                rx_next = {rx_reg[14:0], sda_s_reg};
                            if (bit_reg == 4'h8 && (!rd_reg || byte_reg == 2'b00))
                                nack_next = sda_s_reg;
                        end
                        default: begin
                            scl_low_next = 1'b1;
                            bit_next = bit_reg + 4'h1;
                            tx_next = {tx_reg[6:0], 1'b0};
                            if (bit_reg == 4'h8) begin
                                bit_next = 4'h0;
                                byte_next = byte_reg + 2'b01;
                                tx_next = (byte_reg == 2'b00) ? wdata_reg[15:8]
                                    : wdata_reg[7:0];
                                if (nack_reg || byte_reg == 2'b10)
                                    st_next = M_STOP;
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    // Data rises with clock high to end the frame
                    if (q_reg == 2'b00)
                        sda_low_next = 1'b1;
                    else if (q_reg == 2'b01)
                        scl_low_next = 1'b0;
                    else if (q_reg == 2'b10)
                        sda_low_next = 1'b0;
                    else begin
                        st_next = M_IDLE;
                        if (rd_reg && !nack_reg)
                            rdata_next = rx_reg;
                    end
                end
                default: st_next = M_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= M_IDLE;
            qc_reg <= 16'h0000;
            q_reg <= 2'b00;
            bit_reg <= 4'h0;
            byte_reg <= 2'b00;
            tx_reg <= 8'h00;
            rx_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            rd_reg <= 1'b0;
            nack_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            st_reg <= st_next;
            qc_reg <= qc_next;
            q_reg <= q_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rd_reg <= rd_next;
            nack_reg <= nack_next;
            scl_low_reg <= scl_low_next;
            sda_low_reg <= sda_low_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Open-drain drivers: enable only to pull low
    assign LINK.m_scl_o = 1'b0;
    assign LINK.m_scl_oe = scl_low_reg;
    assign LINK.m_sda_o = 1'b0;
    assign LINK.m_sda_oe = sda_low_reg;
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;
endmodule // dac_code_master

// file: dac_code_port.sv
// Device end: two-wire slave loading a 10-bit converter code
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns

// Contract
// - Start begins capture of next eight bits
// - First byte: 7-bit address plus direction
// - Address 00011xx selects the device
// - Master sends 0x18 write, 0x19 read
// - Matched address acked low through ninth pulse
// - Data changes only while clock low
// - Eight-bit blocks, ack each received block
// - Exactly two data bytes; ack second byte
// - Stop ends the transfer
// - Write high byte first, MSB first
// - Full 16 bits copied to code register
// - Bit 15 is active-high software power-down
// - Bits 13..4 form the code
// - Read returns high byte first, MSB first
// - Input word cleared after a read
// - Active-low pin forces power-down asynchronously
module dac_code_port (
    // System
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Power-down pin, active low
    input wire logic PWR_DOWN_N,
    // Converter side
    output logic [dac_link_pkg::CODE_W-1:0] CONVERTER_CODE_BITS,
    output logic POWER_DOWN_CONTROL,
    output logic POWER_DOWN,
    output logic [15:0] INPUT_WORD,
    // Link
    dac_link_if.device LINK
);
    import dac_link_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_WBYTE = 3'b011,
        ST_WACK = 3'b100,
        ST_RBYTE = 3'b101,
        ST_MACK = 3'b110
    } d_state_t;

    // Address check with the two low bits ignored
    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:3] == ADDR_MATCH_TOP);
    endfunction

    d_state_t st_reg, st_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] hi_reg, hi_next;
    logic byte_reg, byte_next;
    logic rd_reg, rd_next;
    logic last_reg, last_next;
    logic low_reg, low_next;
    logic [15:0] word_reg, word_next;
    logic [15:0] dac_reg, dac_next;
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_p_reg, sda_p_reg;
    logic scl_s, sda_s;
    logic rise, fall, start_ev, stop_ev;
    logic [7:0] rx_byte;

    ////////////////////////////////////////////////////////////////////////
    // Line synchronisers and previous samples for edge finding
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], LINK.scl_line};
            sda_sync_reg <= {sda_sync_reg[0], LINK.sda_line};
            scl_p_reg <= scl_sync_reg[1];
            sda_p_reg <= sda_sync_reg[1];
        end
    end

    // Clock edges and bus conditions
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign rise = scl_s & ~scl_p_reg;
    assign fall = ~scl_s & scl_p_reg;
    assign start_ev = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
    assign stop_ev = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
    assign rx_byte = {sh_reg[6:0], sda_s};

    ////////////////////////////////////////////////////////////////////////
    // Slave sequencer next state
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        hi_next = hi_reg;
        byte_next = byte_reg;
        rd_next = rd_reg;
        last_next = last_reg;
        low_next = low_reg;
        word_next = word_reg;
        dac_next = dac_reg;
        if (start_ev) begin
            // Repeated start drops any partial word
            st_next = ST_ADDR;
            cnt_next = 3'b000;
            last_next = 1'b0;
            low_next = 1'b0;
            byte_next = 1'b0;
        end else if (stop_ev) begin
            st_next = ST_IDLE;
            last_next = 1'b0;
            low_next = 1'b0;
        end else begin
            case (st_reg)
                ST_ADDR: begin
                    if (rise) begin
                        sh_next = rx_byte;
                        cnt_next = cnt_reg + 3'b001;
                        if (cnt_reg == 3'b111) begin
                            if (addr_hit(rx_byte)) begin
                                last_next = 1'b1;
                                rd_next = rx_byte[0];
                            end else
                                st_next = ST_IDLE;
                        end
                    end else if (fall && last_reg) begin
                        // Pull low in the clock-low time before pulse 9
                        last_next = 1'b0;
                        low_next = 1'b1;
                        st_next = ST_AACK;
                    end
                end
                ST_AACK: begin
                    if (fall) begin
                        cnt_next = 3'b000;
                        byte_next = 1'b0;
                        if (rd_reg) begin
                            sh_next = word_reg[15:8];
                            low_next = ~word_reg[15];
                            st_next = ST_RBYTE;
                        end else begin
                            low_next = 1'b0;
                            st_next = ST_WBYTE;
                        end
                    end
                end
                ST_WBYTE: begin
                    if (rise) begin
                        sh_next = rx_byte;
                        cnt_next = cnt_reg + 3'b001;
                        if (cnt_reg == 3'b111)
                            last_next = 1'b1;
                    end else if (fall && last_reg) begin
                        last_next = 1'b0;
                        low_next = 1'b1;
                        st_next = ST_WACK;
                        if (!byte_reg)
                            hi_next = sh_reg;
                        else begin
                            word_next = {hi_reg, sh_reg};
                            dac_next = {hi_reg, sh_reg};
                        end
                    end
                end
                ST_WACK: begin
                    if (fall) begin
                        low_next = 1'b0;
                        cnt_next = 3'b000;
                        // Bytes past the second get no ack
                        if (!byte_reg) begin
                            byte_next = 1'b1;
                            st_next = ST_WBYTE;
                        end else
                            st_next = ST_IDLE;
                    end
                end
                ST_RBYTE: begin
                    if (fall) begin
                        if (cnt_reg == 3'b111) begin
                            low_next = 1'b0;
                            cnt_next = 3'b000;
                            st_next = ST_MACK;
                            if (byte_reg)
                                word_next = WORD_RESET;
                        end else begin
                            cnt_next = cnt_reg + 3'b001;
                            low_next = ~sh_reg[6];
                            sh_next = {sh_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    // Master not acknowledging ends the read
                    if (rise && (sda_s || byte_reg))
                        st_next = ST_IDLE;
                    else if (fall) begin
                        byte_next = 1'b1;
                        sh_next = word_reg[7:0];
                        low_next = ~word_reg[7];
                        st_next = ST_RBYTE;
                    end
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 3'b000;
            sh_reg <= 8'h00;
            hi_reg <= 8'h00;
            byte_reg <= 1'b0;
            rd_reg <= 1'b0;
            last_reg <= 1'b0;
            low_reg <= 1'b0;
            word_reg <= WORD_RESET;
            dac_reg <= DAC_RESET;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            hi_reg <= hi_next;
            byte_reg <= byte_next;
            rd_reg <= rd_next;
            last_reg <= last_next;
            low_reg <= low_next;
            word_reg <= word_next;
            dac_reg <= dac_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign LINK.d_sda_o = 1'b0;
    assign LINK.d_sda_oe = low_reg;
    assign CONVERTER_CODE_BITS = dac_reg[CODE_MSB:CODE_LSB];
    assign POWER_DOWN_CONTROL = dac_reg[PD_BIT];
    // Pin acts without the clock
    assign POWER_DOWN = ~PWR_DOWN_N | dac_reg[PD_BIT];
    assign INPUT_WORD = word_reg;
endmodule // dac_code_port

// file: dac_link_monitor.sv
// Protocol checker for the two-wire link between master and port
`timescale 1ns/1ns
module dac_link_monitor (
    // System
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Link
    input wire logic d_sda_oe,
    input wire logic scl_line,
    input wire logic sda_line
);
    logic scl_p_reg, sda_p_reg, rd_reg;
    logic [4:0] pcnt_reg;
    logic [7:0] sh_reg;
    logic [3:0] lowc_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pulse count since start, direction bit and time spent with clock low
    // The count includes the clock rise that sets up the stop: 28 per frame
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_p_reg <= 1'h1;
            sda_p_reg <= 1'h1;
            rd_reg <= 1'h0;
            pcnt_reg <= 5'h00;
            sh_reg <= 8'h00;
            lowc_reg <= 4'h0;
        end else begin
            scl_p_reg <= scl_line;
            sda_p_reg <= sda_line;
            lowc_reg <= scl_line ? 4'h0 : lowc_reg + {3'h0, lowc_reg != 4'hF};
            if (scl_p_reg && scl_line && sda_p_reg && !sda_line) begin
                pcnt_reg <= 5'h00;
            end else if (scl_line && !scl_p_reg) begin
                pcnt_reg <= pcnt_reg + 5'h01;
                sh_reg <= {sh_reg[6:0], sda_line};
                if (pcnt_reg == 5'h07) begin
                    rd_reg <= sda_line;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    // Start and stop: data edge while clock stays high
    sequence s_start;
        scl_line && $past(scl_line) && $fell(sda_line);
    endsequence
    sequence s_stop;
        scl_line && $past(scl_line) && $rose(sda_line);
    endsequence

    chk_start_idle: assert property (s_start |->
        pcnt_reg == 5'h00 || pcnt_reg == 5'h1C)
        else $error("start inside a frame");
    chk_stop_end: assert property (s_stop |-> pcnt_reg == 5'h1C)
        else $error("stop not after the stop setup pulse");
    chk_two_bytes: assert property ($rose(scl_line) |->
        pcnt_reg <= 5'h1B)
        else $error("clock pulse beyond the stop setup");
    chk_addr_byte: assert property (pcnt_reg == 5'h08 |->
        sh_reg == 8'h18 || sh_reg == 8'h19)
        else $error("address byte is neither write nor read");
    chk_drive_slots: assert property ($rose(d_sda_oe) |->
        pcnt_reg == 5'h08 || pcnt_reg == 5'h11 || pcnt_reg == 5'h1A ||
        (rd_reg && pcnt_reg > 5'h08))
        else $error("port drives data line outside its slots");
    chk_ack_held: assert property ($rose(scl_line) &&
        (pcnt_reg == 5'h08 || !rd_reg && (pcnt_reg == 5'h11 ||
        pcnt_reg == 5'h1A)) |-> d_sda_oe [*8])
        else $error("acknowledge not held through the pulse");
    chk_rd_release: assert property ($rose(scl_line) && rd_reg &&
        (pcnt_reg == 5'h11 || pcnt_reg == 5'h1A) |-> !d_sda_oe [*8])
        else $error("port holds data line during master acknowledge");
    chk_dev_edge: assert property ($changed(d_sda_oe) |->
        lowc_reg >= 4'h2 && lowc_reg <= 4'hA)
        else $error("port changed data line outside clock low");
endmodule // dac_link_monitor

// file: i2c_dac_code_port_bench.sv
// Self-checking bench: master and converter port joined over the link
`timescale 1ns/1ns
module i2c_dac_code_port_bench;
    import dac_link_pkg::*;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic pwr_down_n = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack, pdc, pd;
    logic [9:0] code;
    logic [15:0] word;
    int error_cnt = 0;
    int samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and the two ends
    always #5 sys_clk = ~sys_clk;
    dac_link_if dac_link_if_i ();
    dac_code_master #(.QTR_CYC(6)) dac_code_master_i (
        .SYS_CLK(sys_clk), .RSTN(rstn), .WB_CYC_I(wb_cyc),
        .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
        .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o),
        .WB_ACK_O(wb_ack), .LINK(dac_link_if_i.master));
    dac_code_port dac_code_port_i (
        .SYS_CLK(sys_clk), .RSTN(rstn), .PWR_DOWN_N(pwr_down_n),
        .CONVERTER_CODE_BITS(code), .POWER_DOWN_CONTROL(pdc),
        .POWER_DOWN(pd), .INPUT_WORD(word), .LINK(dac_link_if_i.device));
    dac_link_monitor dac_link_monitor_i (
        .SYS_CLK(sys_clk), .RSTN(rstn), .d_sda_oe(dac_link_if_i.d_sda_oe),
        .scl_line(dac_link_if_i.scl_line), .sda_line(dac_link_if_i.sda_line));

    ////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        check_val(what, {31'h0, exp}, {31'h0, got});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        @(posedge sys_clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        rdat = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        wb_sel <= 4'h0;
        if (n >= 50) begin
            error_cnt++;
            end_sim();
        end
    endtask
    // Run one link frame and wait for the master to go idle
    task automatic xfer(input logic rd_op, input logic [15:0] w);
        logic [31:0] r;
        int n;
        if (!rd_op) begin
            wb_cycle(1'h1, REG_DATA, {16'h0000, w}, r);
        end
        wb_cycle(1'h1, REG_CTRL, {30'h0, rd_op, 1'h1}, r);
        n = 0;
        do begin
            wb_cycle(1'h0, REG_STAT, 32'h0, r);
            n++;
        end while (r[STAT_BUSY] !== 1'h0 && n < 1000);
        if (n >= 1000) begin
            error_cnt++;
            end_sim();
        end
        check_bit("nack flag", 1'h0, r[STAT_NACK]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        logic [31:0] r;
        check_val("code at reset", 32'h0, {22'h0, code});
        check_val("word at reset", 32'h0, {16'h0, word});
        check_bit("power-down at reset", 1'h0, pd);
        wb_cycle(1'h0, 8'h0C, 32'h0, r);
        check_val("unmapped read", 32'h0, r);
        $display("test reset done");
    endtask
    task automatic test_write();
        logic [15:0] w [3] = '{16'h8FF0, 16'hC00F, 16'h4AB5};
        foreach (w[i]) begin
            xfer(1'h0, w[i]);
            check_val("word", {16'h0, w[i]}, {16'h0, word});
            check_val("code", {22'h0, w[i][13:4]}, {22'h0, code});
            check_bit("soft power-down", w[i][15], pdc);
            check_bit("power-down out", w[i][15], pd);
        end
        $display("test write done");
    endtask
    task automatic test_read();
        logic [31:0] r;
        xfer(1'h1, 16'h0000);
        wb_cycle(1'h0, REG_DATA, 32'h0, r);
        check_val("read data", 32'h0000_4AB5, r);
        check_val("word after read", 32'h0, {16'h0, word});
        check_val("code after read", 32'h0AB, {22'h0, code});
        xfer(1'h1, 16'h0000);
        wb_cycle(1'h0, REG_DATA, 32'h0, r);
        check_val("second read data", 32'h0, r);
        $display("test read done");
    endtask
    task automatic test_pin();
        @(posedge sys_clk);
        pwr_down_n <= 1'h0;
        #1;
        check_bit("pin power-down", 1'h1, pd);
        check_bit("soft bit kept", 1'h0, pdc);
        @(posedge sys_clk);
        pwr_down_n <= 1'h1;
        #1;
        check_bit("pin released", 1'h0, pd);
        $display("test pin done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (4) @(posedge sys_clk);
        test_reset();
        test_write();
        test_read();
        test_pin();
        end_sim();
    end
endmodule // i2c_dac_code_port_bench
